// >>> verilog/bpm_cfg.svh
`ifndef BPM_CFG_SVH
`define BPM_CFG_SVH
`define BPM_OFS_SELECT 8'h00
`define BPM_OFS_STATUS 8'h04
`define BPM_OFS_COUNT0 8'h08
`define BPM_OFS_LAST 8'h20
`define BPM_SEL_RESET 32'h0000_0000
`define BPM_MODE_LSB 0
`define BPM_FIELD1_LSB 20
`define BPM_FIELD_STEP 3
`define BPM_CLK_MHZ 133
`endif

// >>> verilog/bpm_pkg.sv
`default_nettype none
package bpm_pkg;
  typedef enum logic [1:0] {
    BPM_HALT,
    BPM_SOUTH,
    BPM_NORTH,
    BPM_SDRAM
  } bpm_mode_type;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bpm_req_type;
  typedef struct packed {
    logic [3:0] southOcc;
    logic [3:0] southDur;
    logic [3:0] northOcc;
    logic [3:0] northDur;
    logic [7:0] pageHit;
    logic [7:0] pageMiss;
  } bpm_events_type;
endpackage : bpm_pkg
`default_nettype wire

// >>> verilog/bpm_monitor.sv
`include "bpm_cfg.svh"
`default_nettype none
// Contract
// - Seven independent 27-bit event counters.
// - A wrapping counter sets its overflow status bit and keeps counting from zero.
// - All overflow status bits are ORed into one interrupt output.
// - Occurrence selection adds one per event.
// - Duration selection adds one per bus clock while the condition holds.
// - Counters advance on the bus clock.
// - Select register holds seven 3-bit fields and a 2-bit mode.
// - Counter 1 field at bits 22..20, counter 7 at 4..2, descending steps.
// - Field top bit 1 picks duration on AHB, page miss on SDRAM.
// - Field top bit 0 picks occurrence on AHB, page hit on SDRAM.
// - Field low two bits pick the specific event; on SDRAM, counters 5 to 7 add four to the bank.
// - Select bits 1..0 hold the mode: halt, south, north, SDRAM.
// - The mode applies to all counters together.
// - Mode 00 halt, 01 south AHB, 10 north AHB.
// - Halt freezes all counters at once; leaving halt clears them.
// - Any select write with a non-halt mode clears and starts counters.
// - Reset puts the select register at zero, which is halt.
// - Writing one to a status bit clears it.
module bpm_monitor #(
  parameter int NUM_COUNTERS = 7,
  parameter int COUNT_WIDTH = 27
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire bpm_pkg::bpm_req_type busReq,
  output logic [31:0] rdData,
  input wire bpm_pkg::bpm_events_type busEvents,
  output logic overflowIrq
);
  import bpm_pkg::*;

  // The field layout is fixed by the select register, so only seven counters fit.
  if (NUM_COUNTERS != 7) begin : g_bad_count
    $error("bpm_monitor: NUM_COUNTERS must be 7");
  end
  // Read data is one word wide, so a counter cannot be wider than 32 bits.
  if (COUNT_WIDTH < 2 || COUNT_WIDTH > 32) begin : g_bad_width
    $error("bpm_monitor: COUNT_WIDTH must lie in 2..32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event inputs come from other bus logic and are synchronised first.
  // The two flops cost two cycles of latency, but each level is still counted once per clock.

  bpm_events_type evtMeta_r;
  bpm_events_type evtSync_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      evtMeta_r <= '0;
      evtSync_r <= '0;
    end else begin
      evtMeta_r <= busEvents;
      evtSync_r <= evtMeta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register decode.

  logic selWrite;
  logic statWrite;
  logic [31:0] select_r;
  bpm_mode_type mode;

  assign selWrite = busReq.wr && (busReq.addr == `BPM_OFS_SELECT);
  assign statWrite = busReq.wr && (busReq.addr == `BPM_OFS_STATUS);
  assign mode = bpm_mode_type'(select_r[`BPM_MODE_LSB +: 2]);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      select_r <= `BPM_SEL_RESET;
    end else if (selWrite) begin
      // Bits above the top field are not stored and read back as zero.
      // select register layout
      select_r <= {9'h000, busReq.wdata[22:0]};
    end
  end

  // A halt write keeps the counts, so software can read a frozen snapshot.
  // leaving halt clears; non-halt write restarts
  logic clearAll;
  assign clearAll = selWrite && (busReq.wdata[1:0] != 2'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Counters.

  logic [COUNT_WIDTH-1:0] count_r [NUM_COUNTERS];
  logic [NUM_COUNTERS-1:0] wrapHit;
  logic [NUM_COUNTERS-1:0] status_r;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_COUNTERS; gi++) begin : g_cnt
      logic [2:0] field;
      logic evtHit;
      assign field = select_r[`BPM_FIELD1_LSB - `BPM_FIELD_STEP * gi +: 3];

      always_comb begin
        evtHit = 1'b0;
        case (mode)
          // south AHB; type and event pick
          BPM_SOUTH: evtHit = field[2] ? evtSync_r.southDur[field[1:0]]
                                       : evtSync_r.southOcc[field[1:0]];
          BPM_NORTH: evtHit = field[2] ? evtSync_r.northDur[field[1:0]]
                                       : evtSync_r.northOcc[field[1:0]];
          // SDRAM page miss or hit, bank from low bits and counter
          BPM_SDRAM: evtHit = field[2] ? evtSync_r.pageMiss[{1'b0, field[1:0]} + 3'(gi & 4)]
                                       : evtSync_r.pageHit[{1'b0, field[1:0]} + 3'(gi & 4)];
          default: evtHit = 1'b0;
        endcase
      end

      assign wrapHit[gi] = evtHit && (&count_r[gi]);

      // Plain binary overflow wraps to zero; the count never saturates.
      // counter on bus clock; one per event or clock
      always_ff @(posedge core_clk) begin
        if (!rst_n || clearAll) begin
          count_r[gi] <= '0;
        end else if (evtHit) begin
          count_r[gi] <= count_r[gi] + 1'b1;
        end
      end

      a_clear_each: assert property (@(posedge core_clk) disable iff (!rst_n)
        clearAll |=> count_r[gi] == '0)
        else $error("Counter not cleared by restart.");

      a_freeze_each: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode == BPM_HALT && !clearAll |=> $stable(count_r[gi]))
        else $error("Counter moved in halt.");

      a_wrap_each: assert property (@(posedge core_clk) disable iff (!rst_n)
        wrapHit[gi] |=> status_r[gi])
        else $error("Wrap did not set its status bit.");
    end
  endgenerate

  // Set beats clear, so a wrap that lands on a clear write is never lost.
  // sticky overflow; write one clears, new wrap wins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~(statWrite ? busReq.wdata[NUM_COUNTERS-1:0] : '0)) | wrapHit;
    end
  end

  assign overflowIrq = |status_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe, zero otherwise.
  // Counters narrower than a word read back with zeros above them.

  logic [31:0] rd_nxt;
  logic [7:0] cntIdx;
  assign cntIdx = (busReq.addr - `BPM_OFS_COUNT0) >> 2;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (busReq.rd) begin
      if (busReq.addr == `BPM_OFS_SELECT) begin
        rd_nxt = select_r;
      end else if (busReq.addr == `BPM_OFS_STATUS) begin
        rd_nxt = 32'(status_r);
      end else if (busReq.addr >= `BPM_OFS_COUNT0 && busReq.addr[1:0] == 2'h0
                   && cntIdx < 8'(NUM_COUNTERS)) begin
        rd_nxt = 32'(count_r[cntIdx[2:0]]);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdData <= 32'h0000_0000;
    end else begin
      rdData <= rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_nonhalt_write;
    selWrite && busReq.wdata[1:0] != 2'h0;
  endsequence

  sequence s_halt_write;
    selWrite && busReq.wdata[1:0] == 2'h0;
  endsequence

  sequence s_halt_settled;
    s_halt_write ##1 !selWrite;
  endsequence

  a_restart_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_nonhalt_write |=> count_r[0] == '0 && count_r[6] == '0)
    else $error("Counters not cleared after select write.");

  a_halt_freezes: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == BPM_HALT && !selWrite |=> $stable(count_r[0]) && $stable(count_r[3]))
    else $error("Counter moved while halted.");

  a_wrap_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrapHit[0] |=> status_r[0] && count_r[0] == '0)
    else $error("Wrap did not set status.");

  a_irq_merge: assert property (@(posedge core_clk) disable iff (!rst_n)
    overflowIrq == (status_r != '0))
    else $error("Interrupt not OR of status.");

  a_clear_status: assert property (@(posedge core_clk) disable iff (!rst_n)
    statWrite && busReq.wdata[1] && !wrapHit[1] |=> !status_r[1])
    else $error("Status bit not cleared by write.");

  a_reset_halt: assert property (@(posedge core_clk)
    !rst_n |=> select_r == 32'h0000_0000)
    else $error("Select not zero after reset.");

  a_count_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode != BPM_HALT && !selWrite && count_r[2] != '1 && g_cnt[2].evtHit
      |=> count_r[2] == $past(count_r[2]) + 1'b1)
    else $error("Counter did not step by one.");

  a_mode_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == BPM_HALT |-> wrapHit == '0)
    else $error("Event seen in halt mode.");

  a_read_latency: assert property (@(posedge core_clk) disable iff (!rst_n)
    busReq.rd && busReq.addr == `BPM_OFS_SELECT && !selWrite |=> rdData == $past(select_r))
    else $error("Select readback wrong.");

  a_halt_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_halt_settled |=> $stable(count_r[5]))
    else $error("Counter moved after halt write.");

  a_halt_no_status: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == BPM_HALT && !statWrite |=> $stable(status_r))
    else $error("Status changed while halted.");

  a_select_store: assert property (@(posedge core_clk) disable iff (!rst_n)
    selWrite |=> select_r[22:0] == $past(busReq.wdata[22:0]) && select_r[31:23] == '0)
    else $error("Select register did not take the write.");

  a_field_ends: assert property (@(posedge core_clk) disable iff (!rst_n)
    g_cnt[0].field == select_r[22:20] && g_cnt[6].field == select_r[4:2])
    else $error("Counter field taken from wrong bits.");

  a_dur_pick: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == BPM_SOUTH && g_cnt[3].field[2]
      |-> g_cnt[3].evtHit == evtSync_r.southDur[g_cnt[3].field[1:0]])
    else $error("Duration event picked wrongly.");

  a_occ_pick: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == BPM_NORTH && !g_cnt[1].field[2]
      |-> g_cnt[1].evtHit == evtSync_r.northOcc[g_cnt[1].field[1:0]])
    else $error("Occurrence event picked wrongly.");

  a_bank_upper: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == BPM_SDRAM && !g_cnt[4].field[2]
      |-> g_cnt[4].evtHit == evtSync_r.pageHit[{1'b1, g_cnt[4].field[1:0]}])
    else $error("Page hit bank picked wrongly.");

  a_dur_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    g_cnt[0].field[2] && g_cnt[0].evtHit && !clearAll && count_r[0] != '1
      |=> count_r[0] == $past(count_r[0]) + 1'b1)
    else $error("Duration counter did not add one clock.");

  a_status_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
    status_r[3] && !(statWrite && busReq.wdata[3]) |=> status_r[3])
    else $error("Status bit dropped without a clear.");

  a_read_status: assert property (@(posedge core_clk) disable iff (!rst_n)
    busReq.rd && busReq.addr == `BPM_OFS_STATUS |=> rdData[6:0] == $past(status_r) && rdData[31:7] == '0)
    else $error("Status readback wrong.");

  a_read_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    !busReq.rd |=> rdData == '0)
    else $error("Read data stood longer than one cycle.");

  a_unmapped_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    busReq.rd && busReq.addr > `BPM_OFS_LAST |=> rdData == '0)
    else $error("Unmapped read returned data.");

  a_event_sync: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(rst_n) && $past(rst_n, 2) |-> evtSync_r == $past(busEvents, 2))
    else $error("Event synchroniser latency wrong.");

  a_irq_reset: assert property (@(posedge core_clk)
    !rst_n |=> !overflowIrq && rdData == '0)
    else $error("Outputs not quiet after reset.");

endmodule : bpm_monitor
`default_nettype wire

// >>> testbench/bpm_event_source.sv
`default_nettype none
// Far-side event source: holds its pattern as levels while active, else stays quiet.
module bpm_event_source (
  input wire logic core_clk,
  input wire logic active,
  input wire bpm_pkg::bpm_events_type pattern,
  output var bpm_pkg::bpm_events_type busEvents
);
  import bpm_pkg::*;
  always_ff @(posedge core_clk) begin
    busEvents <= active ? pattern : '0;
  end
endmodule : bpm_event_source
`default_nettype wire

// >>> testbench/bus_perf_event_counters_tb_top.sv
`default_nettype none
module bus_perf_event_counters_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bpm_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic active = 1'b0;
  logic rdPend = 1'b0;
  logic [31:0] rdData;
  logic overflowIrq;
  logic [31:0] seed = 32'h0743;
  logic [31:0] expQ[$];
  int failures = 0;
  int checks = 0;
  bpm_req_type busReq = '0;
  bpm_events_type pattern = '0;
  bpm_events_type busEvents;
  // Narrow counters so a wrap fits in a short run.
  bpm_monitor #(.COUNT_WIDTH(6)) i_bpm_monitor (.core_clk(core_clk), .rst_n(rst_n),
    .busReq(busReq), .rdData(rdData), .busEvents(busEvents), .overflowIrq(overflowIrq));
  bpm_event_source i_bpm_event_source (.core_clk(core_clk), .active(active),
    .pattern(pattern), .busEvents(busEvents));
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic op(input logic [7:0] a, input logic [31:0] d, input logic w,
                    input logic [31:0] e);
    @(posedge core_clk);
    busReq <= '{a, d, w, !w};
    if (!w) expQ.push_back(e);
    @(posedge core_clk);
    busReq <= '0;
  endtask : op
  task automatic burst(input int n);
    @(posedge core_clk);
    active <= 1'b1;
    repeat (n) @(posedge core_clk);
    active <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask : burst
  function automatic logic hit(input logic [31:0] s, input int k);
    logic [2:0] f;
    f = s[22-3*k -: 3];
    case (s[1:0])
      2'h1: return f[2] ? pattern.southDur[f[1:0]] : pattern.southOcc[f[1:0]];
      2'h2: return f[2] ? pattern.northDur[f[1:0]] : pattern.northOcc[f[1:0]];
      2'h3: return f[2] ? pattern.pageMiss[{k > 3, f[1:0]}] : pattern.pageHit[{k > 3, f[1:0]}];
      default: return 1'b0;
    endcase
  endfunction : hit
  // Read data is registered, so the note is due one edge after the strobe.
  always @(posedge core_clk) begin
    if (rdPend) check(rdData, expQ.pop_front());
    rdPend <= busReq.rd;
  end
  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    complete_run();
  end
  initial begin
    logic [31:0] sel;
    int n;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    op(8'h00, 32'h0, 1'b0, 32'h0);
    op(8'h40, 32'h0, 1'b0, 32'h0);
    for (int m = 0; m < 7; m++) begin
      sel = xs();
      sel[1:0] = 2'(m % 3 + 1);
      n = 1 + int'(xs() % 40);
      pattern <= bpm_events_type'(xs());
      op(8'h00, sel, 1'b1, 32'h0);
      burst(n);
      op(8'h00, sel & 32'hFFFF_FFFC, 1'b1, 32'h0);
      burst(5);
      op(8'h00, 32'h0, 1'b0, sel & 32'h007F_FFFC);
      for (int k = 0; k < 7; k++) begin
        op(8'(8 + 4 * k), 32'h0, 1'b0, hit(sel, k) ? 32'(n) : 32'h0);
      end
      $display("round %0d mode %0d done", m, sel[1:0]);
    end
    pattern <= '1;
    op(8'h00, 32'h3, 1'b1, 32'h0);
    burst(70);
    op(8'h08, 32'h0, 1'b0, 32'h6);
    op(8'h04, 32'h0, 1'b0, 32'h7F);
    check({31'h0, overflowIrq}, 32'h1);
    op(8'h04, 32'h7F, 1'b1, 32'h0);
    op(8'h04, 32'h0, 1'b0, 32'h0);
    check({31'h0, overflowIrq}, 32'h0);
    $display("overflow test done");
    op(8'h00, 32'h4, 1'b1, 32'h0);
    op(8'h08, 32'h0, 1'b0, 32'h6);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    op(8'h00, 32'h0, 1'b0, 32'h0);
    op(8'h08, 32'h0, 1'b0, 32'h0);
    $display("reset test done");
    repeat (2) @(posedge core_clk);
    complete_run();
  end
endmodule : bus_perf_event_counters_tb_top
`default_nettype wire
